/* tick_triggered_adc_control_bench.sv */
// Purpose: Self-checking bench for the converter control.
// Assumes: Ideal comparator; result equals the input code.
// Notes:   The internal 1 kHz source is too slow to run here.
`timescale 1ns/100ps
`default_nettype none
module tick_triggered_adc_control_bench;
   logic clk = 1'b0, nrst = 1'b0, ext_ref = 1'b0, sw_start = 1'b0, busy_prev = 1'b0;
   logic alt_tick = 1'b0, irq_ack = 1'b0, comp_above, sample_en, busy, conv_done, conv_irq;
   logic [11:0] vin = 12'h000, dac_code;
   logic [11:0] codes [3] = '{12'h000, 12'hfff, 12'h5a3};
   logic [4:0] chan_sel;
   ttadc_pkg::ttadc_tick_cfg_type tcfg = '0;
   ttadc_pkg::ttadc_conv_cfg_type ccfg = '0;
   ttadc_pkg::ttadc_result_type res;
   int miscompares = 0, samples_checked = 0, cycles = 0, starts = 0;
   // ==========================================================
   // Design and far side
   ttadc_ctrl u_dut (.clk(clk), .nrst(nrst), .tick_timer_control(tcfg),
      .external_reference_clock(ext_ref), .conv_cfg(ccfg), .sw_start(sw_start),
      .alt_clk_tick(alt_tick), .comp_above(comp_above), .irq_ack(irq_ack),
      .analog_channel_sel(chan_sel), .sample_en(sample_en), .dac_code(dac_code),
      .busy(busy), .conv_done(conv_done), .conv_irq(conv_irq), .result(res));
   ttadc_pot_model u_pot (.vin(vin), .dac_code(dac_code), .comp_above(comp_above));
   // Clock, slow step enable every fourth cycle, and a hang limit.
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      alt_tick <= (cycles % 4 == 0);
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end
   // Starts are counted on settled values so a doubled start shows up.
   always @(negedge clk) begin
      if (busy === 1'b1 && busy_prev !== 1'b1) starts++;
      busy_prev = busy;
   end
   // ==========================================================
   // Tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic start_sw(input logic [11:0] v);
      @(posedge clk);
      vin <= v;
      sw_start <= 1'b1;
      @(posedge clk);
      sw_start <= 1'b0;
   endtask
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         ext_ref <= 1'b1;
         @(posedge clk);
         ext_ref <= 1'b0;
      end
   endtask
   task automatic ack();
      @(posedge clk);
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      @(negedge clk);
   endtask
   // Bounded wait; a missing finish then counts as a mismatch.
   task automatic wait_done();
      int n;
      n = 0;
      @(negedge clk);
      while (conv_done !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      // A conversion that never finishes within the limit counts as a mismatch.
      if (conv_done !== 1'b1) miscompares++;
      @(negedge clk);
   endtask
   task automatic report_and_stop();
      $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      check(res, 16'h0000);
      @(posedge clk);
      ccfg <= '{1'b0, 1'b1, 5'h13, 1'b1};
      foreach (codes[i]) begin
         start_sw(codes[i]);
         wait_done();
         check(res, {4'h0, codes[i]});
         check(16'(conv_irq), 16'h0001);
         check(16'(chan_sel), 16'h0013);
         ack();
         check(16'(conv_irq), 16'h0000);
      end
      $display("Test software starts ended.");
      @(posedge clk);
      ccfg <= '{1'b1, 1'b1, ttadc_pkg::CH_ZERO, 1'b1};
      start_sw(12'h7c1);
      repeat (4) @(negedge clk);
      check(16'(busy), 16'h0000);
      @(posedge clk);
      tcfg <= '{3'h1, 1'b1};
      starts = 0;
      for (int k = 1; k < 3; k++) begin
         ext_pulses(15);
         @(negedge clk);
         check(16'(starts), 16'(k - 1));
         ext_pulses(1);
         wait_done();
         check(16'(starts), 16'(k));
         check(res, 16'h07c1);
         check(16'(chan_sel), 16'h0000);
         ack();
      end
      $display("Test tick starts ended.");
      @(posedge clk);
      tcfg <= '0;
      ccfg <= '{1'b0, 1'b0, 5'h01, 1'b0};
      start_sw(12'h801);
      repeat (16) @(negedge clk);
      check(16'(busy), 16'h0001);
      wait_done();
      check(res, 16'h0801);
      check(16'(conv_irq), 16'h0000);
      $display("Test slow clock ended.");
      report_and_stop();
   end
endmodule
`default_nettype wire

/* ttadc_ctrl.sv */
// Purpose: Converter control started by software or by the periodic tick timer.
// Assumes: Comparator output is synchronous to clk; the bus clock or the alternate enable steps the converter.
// Notes:   The analog core lives outside; this block runs the 12-bit search.
`timescale 1ns/100ps
`default_nettype none
module ttadc_ctrl (
   input  wire logic                          clk,
   input  wire logic                          nrst,
   input  wire ttadc_pkg::ttadc_tick_cfg_type tick_timer_control,
   input  wire logic                          external_reference_clock,
   input  wire ttadc_pkg::ttadc_conv_cfg_type conv_cfg,
   input  wire logic                          sw_start,
   input  wire logic                          alt_clk_tick,
   input  wire logic                          comp_above,
   input  wire logic                          irq_ack,
   output logic [ttadc_pkg::CH_W-1:0]         analog_channel_sel,
   output logic                               sample_en,
   output logic [ttadc_pkg::RES_W-1:0]        dac_code,
   output logic                               busy,
   output logic                               conv_done,
   output logic                               conv_irq,
   output ttadc_pkg::ttadc_result_type        result
);
   // ==========================================================
   // Tick timer and start selection
   logic tick_event;
   logic start_req;
   logic conv_clk_en;

   ttadc_tick_timer u_tick (
      .clk          (clk),
      .nrst         (nrst),
      .cfg          (tick_timer_control),
      .ext_ref_tick (external_reference_clock),
      .tick_event   (tick_event)
   );

   // Only the selected source may start; the other is ignored entirely.
   assign start_req   = conv_cfg.hw_trig_en ? tick_event : sw_start;
   // Bus clock selection steps every cycle, otherwise on the alternate enable.
   assign conv_clk_en = conv_cfg.clk_sel_bus ? 1'b1 : alt_clk_tick;

   // ==========================================================
   // Successive-approximation sequencer
   ttadc_pkg::ttadc_state_type state_q;
   ttadc_pkg::ttadc_state_type state_d;
   logic [ttadc_pkg::RES_W-1:0] sar_q;
   logic [ttadc_pkg::RES_W-1:0] sar_d;
   logic [3:0]                  bit_q;
   logic [3:0]                  bit_d;
   logic [ttadc_pkg::CH_W-1:0]  ch_q;
   logic [ttadc_pkg::RES_W-1:0] trial_bit;
   logic                        irq_q;
   logic                        irq_d;
   ttadc_pkg::ttadc_result_type res_q;
   logic                        finish;

   assign trial_bit = ttadc_pkg::RES_W'(1) << bit_q;
   assign finish    = (state_q == ttadc_pkg::TTADC_STEP) && conv_clk_en && (bit_q == 4'h0);

   // Next-state logic; a start while busy is dropped so one tick is one conversion.
   always_comb begin
      state_d = state_q;
      sar_d   = sar_q;
      bit_d   = bit_q;
      unique case (state_q)
         ttadc_pkg::TTADC_IDLE: begin
            if (start_req) begin
               state_d = ttadc_pkg::TTADC_SAMPLE;
            end
         end
         ttadc_pkg::TTADC_SAMPLE: begin
            if (conv_clk_en) begin
               state_d = ttadc_pkg::TTADC_STEP;
               bit_d   = ttadc_pkg::MSB_IDX;
               sar_d   = ttadc_pkg::RES_W'(1) << ttadc_pkg::MSB_IDX;
            end
         end
         ttadc_pkg::TTADC_STEP: begin
            if (conv_clk_en) begin
               // Keep the trial bit when the input is at or above the trial code.
               sar_d = comp_above ? sar_q : (sar_q & ~trial_bit);
               if (bit_q != 4'h0) begin
                  bit_d = bit_q - 4'h1;
                  sar_d = sar_d | (trial_bit >> 1);
               end else begin
                  state_d = ttadc_pkg::TTADC_DONE;
               end
            end
         end
         ttadc_pkg::TTADC_DONE: begin
            state_d = ttadc_pkg::TTADC_IDLE;
         end
      endcase
   end

   // Sticky request; a completion in the ack cycle wins over the ack.
   assign irq_d = (finish && conv_cfg.conversion_interrupt_enable) ? 1'b1
                : (irq_ack ? 1'b0 : irq_q);

   // Sequencer registers.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ttadc_pkg::TTADC_IDLE;
         sar_q   <= '0;
         bit_q   <= 4'h0;
      end else begin
         state_q <= state_d;
         sar_q   <= sar_d;
         bit_q   <= bit_d;
      end
   end

   // Channel latched at start so a reconfiguration cannot corrupt a conversion.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ch_q <= ttadc_pkg::CH_ZERO;
      end else if (state_q == ttadc_pkg::TTADC_IDLE && start_req) begin
         ch_q <= conv_cfg.channel;
      end
   end

   // Result bytes and interrupt flag.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         res_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         if (finish) begin
            res_q.result_high_byte <= {4'h0, sar_d[11:8]};
            res_q.result_low_byte  <= sar_d[7:0];
         end
      end
   end

   // ==========================================================
   // Outputs
   assign analog_channel_sel = ch_q;
   assign sample_en          = (state_q == ttadc_pkg::TTADC_SAMPLE);
   assign dac_code           = sar_q;
   assign busy               = (state_q != ttadc_pkg::TTADC_IDLE);
   assign conv_done          = (state_q == ttadc_pkg::TTADC_DONE);
   assign conv_irq           = irq_q;
   assign result             = res_q;
endmodule
`default_nettype wire

/* ttadc_ctrl_checker.sv */
// Purpose: Port relations of the converter control.
// Assumes: One clock; nrst is synchronous and active low.
// Notes:   Bound to ttadc_ctrl below the module.
`timescale 1ns/100ps
`default_nettype none
module ttadc_ctrl_checker (
   input wire logic                          clk,
   input wire logic                          nrst,
   input wire ttadc_pkg::ttadc_conv_cfg_type conv_cfg,
   input wire logic                          sw_start,
   input wire logic                          irq_ack,
   input wire logic                          alt_clk_tick,
   input wire logic [ttadc_pkg::RES_W-1:0]   dac_code,
   input wire logic [ttadc_pkg::CH_W-1:0]    analog_channel_sel,
   input wire logic                          sample_en,
   input wire logic                          busy,
   input wire logic                          conv_done,
   input wire logic                          conv_irq,
   input wire ttadc_pkg::ttadc_result_type   result
);
   // ==========================================================
   // Assertions
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_sw_go; !busy && !conv_cfg.hw_trig_en && sw_start |=> busy && sample_en; endproperty
   a_sw_go: assert property (p_sw_go) else $error("software start not taken");
   // The sample phase ends on the first step enable, which is every cycle on the bus clock.
   property p_smp; sample_en && (conv_cfg.clk_sel_bus || alt_clk_tick) |=> !sample_en && busy;
      endproperty
   a_smp: assert property (p_smp) else $error("sample phase longer than one cycle");
   property p_wait; sample_en && !conv_cfg.clk_sel_bus && !alt_clk_tick |=> sample_en;
      endproperty
   a_wait: assert property (p_wait) else $error("sample phase left without a step enable");
   property p_trial; $fell(sample_en) |-> dac_code == 12'h800; endproperty
   a_trial: assert property (p_trial) else $error("first trial code is not the top bit");
   property p_len; $rose(busy) && conv_cfg.clk_sel_bus |-> ##13 conv_done; endproperty
   a_len: assert property (p_len) else $error("bus clock conversion length wrong");
   property p_end; conv_done |=> !conv_done && !busy; endproperty
   a_end: assert property (p_end) else $error("converter not idle after finish");
   property p_irq; conv_done && conv_cfg.conversion_interrupt_enable |-> ##[0:1] conv_irq;
      endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
   property p_hold; conv_irq && !irq_ack |=> conv_irq; endproperty
   a_hold: assert property (p_hold) else $error("interrupt dropped without ack");
   property p_clr; conv_irq && irq_ack && !busy |=> !conv_irq; endproperty
   a_clr: assert property (p_clr) else $error("interrupt not cleared by ack");
   property p_keep; !busy |=> $stable(result); endproperty
   a_keep: assert property (p_keep) else $error("result changed while idle");
   property p_chan; $rose(busy) |-> analog_channel_sel == $past(conv_cfg.channel); endproperty
   a_chan: assert property (p_chan) else $error("channel not latched at start");
endmodule
bind ttadc_ctrl ttadc_ctrl_checker u_chk (.clk(clk), .nrst(nrst), .conv_cfg(conv_cfg),
   .sw_start(sw_start), .irq_ack(irq_ack), .alt_clk_tick(alt_clk_tick),
   .dac_code(dac_code), .analog_channel_sel(analog_channel_sel),
   .sample_en(sample_en), .busy(busy), .conv_done(conv_done), .conv_irq(conv_irq),
   .result(result));
`default_nettype wire

/* ttadc_pkg.sv */
// Purpose: Shared constants and types for the tick-triggered converter control.
// Assumes: One 100 MHz clock; all control bits arrive as plain ports.
// Notes:   Every offset and timing count used by the logic lives here; the divider and bit counter widths are set in the modules.
package ttadc_pkg;
   // ==========================================================
   // Clock and tick timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned INT_TICK_HZ     = 1_000;
   localparam int unsigned INT_DIV_CYCLES  = CLK_HZ / INT_TICK_HZ;
   localparam int unsigned PERIOD_SEL_W    = 3;
   localparam int unsigned PERIOD_CNT_W    = 11;
   // Period codes: 0 stops the timer, code n gives 2**(n+3) source ticks.
   localparam logic [2:0]  PERIOD_OFF      = 3'h0;
   localparam logic [2:0]  PERIOD_1024     = 3'h7;
   localparam int unsigned PERIOD_BASE_SH  = 3;

   // ==========================================================
   // Converter
   localparam int unsigned RES_W           = 12;
   localparam int unsigned CH_W            = 5;
   localparam logic [4:0]  CH_ZERO         = 5'h00;
   localparam logic [3:0]  MSB_IDX         = 4'hb;

   typedef enum logic [1:0] {
      TTADC_IDLE   = 2'b00,
      TTADC_SAMPLE = 2'b01,
      TTADC_STEP   = 2'b10,
      TTADC_DONE   = 2'b11
   } ttadc_state_type;

   typedef struct packed {
      logic [PERIOD_SEL_W-1:0] period_sel;
      logic                    use_ext_clk;
   } ttadc_tick_cfg_type;

   typedef struct packed {
      logic            hw_trig_en;
      logic            conversion_interrupt_enable;
      logic [CH_W-1:0] channel;
      logic            clk_sel_bus;
   } ttadc_conv_cfg_type;

   typedef struct packed {
      logic [7:0] result_high_byte;
      logic [7:0] result_low_byte;
   } ttadc_result_type;
endpackage

/* ttadc_pot_model.sv */
// Purpose: Potentiometer on an analog input seen through an ideal comparator.
// Assumes: The bench holds the input voltage as a 12-bit code.
// Notes:   No settling delay is modelled, so the answer is always prompt.
`timescale 1ns/100ps
`default_nettype none
module ttadc_pot_model (
   input  wire logic [11:0] vin,
   input  wire logic [11:0] dac_code,
   output logic             comp_above
);
   // ==========================================================
   // Comparator
   // High when the input is at or above the trial code.
   assign comp_above = (vin >= dac_code);
endmodule
`default_nettype wire

/* ttadc_tick_timer.sv */
// Purpose: Periodic tick timer producing a one-cycle event pulse.
// Assumes: The external reference arrives as a one-cycle enable on clk.
// Notes:   The internal nominal 1 kHz source is a divider from clk.
`timescale 1ns/100ps
`default_nettype none
module ttadc_tick_timer (
   input  wire logic                         clk,
   input  wire logic                         nrst,
   input  wire ttadc_pkg::ttadc_tick_cfg_type cfg,
   input  wire logic                         ext_ref_tick,
   output logic                              tick_event
);
   // ==========================================================
   // Source selection
   logic [16:0] div_q;
   logic [16:0] div_d;
   logic        int_tick;
   logic        src_tick;
   logic [ttadc_pkg::PERIOD_CNT_W-1:0] cnt_q;
   logic [ttadc_pkg::PERIOD_CNT_W-1:0] cnt_d;
   logic [ttadc_pkg::PERIOD_CNT_W-1:0] last_cnt;
   logic        running;
   logic        wrap;

   // Internal 1 kHz divider, free running so the source is always ready.
   assign int_tick = (div_q == 17'(ttadc_pkg::INT_DIV_CYCLES - 1));
   assign div_d    = int_tick ? 17'h0 : div_q + 17'h1;
   assign src_tick = cfg.use_ext_clk ? ext_ref_tick : int_tick;
   assign running  = (cfg.period_sel != ttadc_pkg::PERIOD_OFF);
   // Code 7 gives 1024 source ticks, 1.024 s from the internal source.
   assign last_cnt = ttadc_pkg::PERIOD_CNT_W'((1 << (cfg.period_sel
                     + ttadc_pkg::PERIOD_BASE_SH)) - 1);
   assign wrap     = running && src_tick && (cnt_q >= last_cnt);
   assign cnt_d    = !running ? '0 : (!src_tick ? cnt_q : (wrap ? '0 : cnt_q + 1'b1));

   // Divider and period counter.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         div_q      <= 17'h0;
         cnt_q      <= '0;
         tick_event <= 1'b0;
      end else begin
         div_q      <= div_d;
         cnt_q      <= cnt_d;
         tick_event <= wrap;
      end
   end
endmodule
`default_nettype wire
